// [verilog/stc_pkg.sv]
// Function
// - four of six modes built here
// - timer mode: count, match, interrupt, clear
// - compare takes effect after high byte
// - auto-capture in every mode but external trigger
// - stop mode forces start field 00
// - capture copies counter each source clock
// - external trigger starts on chosen edge
// - trigger-stop: opposite edge clears, halts quietly
// - trigger-start: ignore edges until match
// - pin filter rejects short pulses
// - filter bypassed in slow and sleep
// - event mode counts pin edges
// - event match checked on opposite edge
// - window mode gates source clock by pin
package stc_pkg;
   // =====================================
   // field encodings
   localparam logic [1:0] STC_START_STOP = 2'h0;   // counter halted
   localparam logic [1:0] STC_START_CMD  = 2'h1;   // command start / positive gating
   localparam logic [1:0] STC_START_RISE = 2'h2;   // rising edge
   localparam logic [1:0] STC_START_FALL = 2'h3;   // falling edge
   localparam logic [2:0] STC_MODE_TIMER = 3'h0;   // plain timer
   localparam logic [2:0] STC_MODE_EXT   = 3'h1;   // external trigger timer
   localparam logic [2:0] STC_MODE_EVENT = 3'h2;   // event counter
   localparam logic [2:0] STC_MODE_WIN   = 3'h3;   // window
   localparam logic [1:0] STC_CLK_SLOW   = 2'h0;   // low-frequency derived
   // =====================================
   // prescaler ratios and noise filter
   localparam int STC_DIV_SLOW  = 128;  // slowest prescale ratio
   localparam int STC_DIV_MID   = 8;    // middle prescale ratio
   localparam int STC_DIV_FAST  = 2;    // fastest prescale ratio
   localparam int STC_NOISE_FC  = 4;    // pulses this long or shorter are noise
   localparam int STC_FILT_CYC  = STC_NOISE_FC + 1; // stable cycles to accept a level
   localparam logic [15:0] STC_CMP_RESET = 16'hffff; // compare reset value
   // =====================================
   // control bundle
   typedef struct packed {
      logic [1:0] startCtl;     // start_control
      logic [2:0] modeSel;      // mode_select
      logic [1:0] srcClkSel;    // source_clock_select
      logic       autoCapEn;    // auto_capture_enable
      logic       trigStopSel;  // trigger_stop_select
   } stc_ctrl_t;
endpackage : stc_pkg

// [verilog/stc_timer.sv]
`timescale 1ns/1ns
module stc_timer (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire stc_pkg::stc_ctrl_t ctrl,        // control fields
   input  wire logic              startWrite,  // pulse: ctrl.startCtl written
   input  wire logic              lowByteWr,   // pulse: compare low byte write
   input  wire logic              highByteWr,  // pulse: compare high byte write
   input  wire logic [7:0]        wrByte,      // byte data
   input  wire logic              stopModeEnter, // pulse: entering STOP mode
   input  wire logic              slowMode,    // low-frequency or sleep operation
   input  wire logic              countInPin,  // count_input_pin
   output logic [1:0]             startState,  // live start field
   output logic [15:0]            countVal,    // up-counter
   output logic [15:0]            captureVal,  // compare_b_capture_reg
   output logic [15:0]            compareVal,  // compare_a_reg in effect
   output logic                   matchIrq     // match_interrupt pulse
);
   // =====================================
   // prescaler: one-cycle source clock enable
   // divider wraps once per slowest period, so every ratio ticks evenly
   logic [6:0] preCnt_q;   // free running divider
   logic       srcTick;    // selected source clock enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         preCnt_q <= 7'h00;
      end else begin
         preCnt_q <= preCnt_q + 7'h01;
      end
   end
   always_comb begin
      case (ctrl.srcClkSel)
         2'h1:    srcTick = (preCnt_q[2:0] == 3'(stc_pkg::STC_DIV_MID - 1));
         2'h2:    srcTick = (preCnt_q[0] == 1'(stc_pkg::STC_DIV_FAST - 1));
         // in slow mode only the low-frequency source is usable
         default: srcTick = (preCnt_q == 7'(stc_pkg::STC_DIV_SLOW - 1));
      endcase
      if (slowMode && ctrl.srcClkSel != stc_pkg::STC_CLK_SLOW) begin
         srcTick = 1'b0;
      end
   end
   // =====================================
   // pin noise filter
   logic [2:0] filtCnt_q;  // cycles the raw pin has differed
   logic       pinFilt_q;  // accepted pin level
   logic       pinPrev_q;  // previous accepted level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         filtCnt_q <= 3'h0;
         pinFilt_q <= 1'b0;
      end else if (slowMode) begin
         pinFilt_q <= countInPin;
         filtCnt_q <= 3'h0;
      end else if (countInPin == pinFilt_q) begin
         filtCnt_q <= 3'h0;
      // a differing level must persist the full window to win
      end else if (filtCnt_q == 3'(stc_pkg::STC_FILT_CYC - 1)) begin
         pinFilt_q <= countInPin;
         filtCnt_q <= 3'h0;
      end else begin
         filtCnt_q <= filtCnt_q + 3'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinPrev_q <= 1'b0;
      end else begin
         pinPrev_q <= pinFilt_q;
      end
   end
   logic pinRise;   // accepted rising edge
   logic pinFall;   // accepted falling edge
   logic trigEdge;  // selected edge
   logic oppEdge;   // opposite edge
   assign pinRise  = pinFilt_q & ~pinPrev_q;
   assign pinFall  = ~pinFilt_q & pinPrev_q;
   assign trigEdge = (ctrl.startCtl == stc_pkg::STC_START_FALL) ? pinFall : pinRise;
   assign oppEdge  = (ctrl.startCtl == stc_pkg::STC_START_FALL) ? pinRise : pinFall;
   // =====================================
   // compare register: shadow low byte, buffer, apply on source tick
   logic [7:0]  lowShadow_q;  // compare_a_low_byte
   logic [15:0] cmdBuf_q;     // written but not yet in effect
   logic        cmpPend_q;    // high byte written
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lowShadow_q <= 8'h00;
      end else if (lowByteWr) begin
         lowShadow_q <= wrByte;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmdBuf_q   <= stc_pkg::STC_CMP_RESET;
         cmpPend_q  <= 1'b0;
         compareVal <= stc_pkg::STC_CMP_RESET;
      // a new high byte outranks a same-cycle apply
      end else if (highByteWr) begin
         cmdBuf_q  <= {wrByte, lowShadow_q};
         cmpPend_q <= 1'b1;
      end else if (cmpPend_q && srcTick) begin
         compareVal <= cmdBuf_q;
         cmpPend_q  <= 1'b0;
      end
   end
   // =====================================
   // start field with STOP override
   // stop forces 00
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         startState <= stc_pkg::STC_START_STOP;
      // stop entry outranks a same-cycle start write
      end else if (stopModeEnter) begin
         startState <= stc_pkg::STC_START_STOP;
      end else if (startWrite) begin
         startState <= ctrl.startCtl;
      end
   end
   // =====================================
   // counting engine
   logic running_q;  // external trigger run state
   logic advance;    // counter steps this cycle
   logic atMatch;    // counter equals compare
   logic matchChk;   // match is evaluated this cycle
   logic enabled;    // start field non-zero
   assign enabled = (startState != stc_pkg::STC_START_STOP);
   assign atMatch = (countVal == compareVal);
   always_comb begin
      advance  = 1'b0;
      matchChk = 1'b0;
      case (ctrl.modeSel)
         stc_pkg::STC_MODE_TIMER: begin
            advance  = srcTick;
            matchChk = srcTick;
         end
         stc_pkg::STC_MODE_EXT: begin
            advance  = srcTick & running_q;
            matchChk = srcTick & running_q;
         end
         stc_pkg::STC_MODE_EVENT: begin
            advance  = trigEdge;
            matchChk = oppEdge;
         end
         stc_pkg::STC_MODE_WIN: begin
            advance  = srcTick & ((startState == stc_pkg::STC_START_CMD) ? pinFilt_q
                                                                        : ~pinFilt_q);
            matchChk = advance;
         end
         // pulse width and pulse output codes are not built
         default: begin
            advance  = 1'b0;
            matchChk = 1'b0;
         end
      endcase
      if (!enabled) begin
         advance  = 1'b0;
         matchChk = 1'b0;
      end
   end
   // external trigger run state
   // leaving the mode or stopping drops the run state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         running_q <= 1'b0;
      end else if (!enabled || ctrl.modeSel != stc_pkg::STC_MODE_EXT) begin
         running_q <= 1'b0;
      end else if (matchChk && atMatch) begin
         running_q <= 1'b0;
      end else if (running_q && ctrl.trigStopSel && oppEdge) begin
         running_q <= 1'b0;
      end else if (!running_q && trigEdge) begin
         running_q <= 1'b1;
      end
   end
   // counter and match interrupt
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         countVal <= 16'h0000;
         matchIrq <= 1'b0;
      end else begin
         matchIrq <= 1'b0;
         // stop field holds the counter at zero
         if (!enabled) begin
            countVal <= 16'h0000;
         end else if (matchChk && atMatch) begin
            countVal <= 16'h0000;
            matchIrq <= 1'b1;
         end else if (ctrl.modeSel == stc_pkg::STC_MODE_EXT && ctrl.trigStopSel &&
                      running_q && oppEdge) begin
            countVal <= 16'h0000;
         end else if (advance) begin
            countVal <= countVal + 16'h0001;
         end
      end
   end
   // =====================================
   // auto-capture
   // capture keeps its last value once disabled
   // copy on each source clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         captureVal <= 16'h0000;
      end else if (ctrl.autoCapEn && enabled && srcTick &&
                   ctrl.modeSel != stc_pkg::STC_MODE_EXT) begin
         captureVal <= countVal;
      end
   end
endmodule : stc_timer

// [bench/stc_timer_monitor.sv]
`timescale 1ns/1ns
// =====================================
// port checker for the timer
module stc_timer_monitor (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire stc_pkg::stc_ctrl_t ctrl,
   input wire logic               startWrite,
   input wire logic               lowByteWr,
   input wire logic               highByteWr,
   input wire logic [7:0]         wrByte,
   input wire logic               stopModeEnter,
   input wire logic               slowMode,
   input wire logic [1:0]         startState,
   input wire logic [15:0]        countVal,
   input wire logic [15:0]        captureVal,
   input wire logic [15:0]        compareVal,
   input wire logic               matchIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0]  lowByte_q;  // last low byte written
   logic [15:0] expCmp_q;   // compare value the last high byte write asks for
   // low byte kept for the pending compare value
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) lowByte_q <= 8'h00;
      else if (lowByteWr) lowByte_q <= wrByte;
   end
   // expected compare value formed at the high byte write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) expCmp_q <= 16'hffff;
      else if (highByteWr) expCmp_q <= {wrByte, lowByte_q};
   end
   sequence s_stop3; (startState == 2'h0) [*3]; endsequence
   sequence s_ext2; (ctrl.modeSel == stc_pkg::STC_MODE_EXT) [*2]; endsequence
   sequence s_cmp_wr; highByteWr && !slowMode; endsequence
   property p_cmp_apply;
      s_cmp_wr |=> ##[0:129] (compareVal == expCmp_q);
   endproperty
   a_stop_clears: assert property (stopModeEnter |=> startState == 2'h0) else $error("stop");
   a_start_loads: assert property (startWrite && !stopModeEnter |=>
      startState == $past(ctrl.startCtl)) else $error("start field");
   a_irq_pulse: assert property (matchIrq |=> !matchIrq) else $error("irq width");
   a_irq_clears: assert property (matchIrq |-> countVal <= 16'h0001) else $error("no clear");
   a_stopped_holds: assert property (s_stop3 |-> $stable(countVal)) else $error("count");
   a_stopped_quiet: assert property (s_stop3 |-> !matchIrq) else $error("irq stopped");
   a_cmp_applies: assert property (p_cmp_apply) else $error("compare");
   a_cap_ext_hold: assert property (s_ext2 |-> $stable(captureVal)) else $error("capture");
endmodule : stc_timer_monitor
bind stc_timer stc_timer_monitor stc_timer_monitor_inst (.clk, .rst_b, .ctrl, .startWrite,
   .lowByteWr, .highByteWr, .wrByte, .stopModeEnter, .slowMode, .startState, .countVal,
   .captureVal, .compareVal, .matchIrq);

// [bench/stc_pulse_src.sv]
`timescale 1ns/1ns
// =====================================
// pulse source driving the count input pin
module stc_pulse_src (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] hiCyc,
   input  wire logic [7:0] loCyc,
   input  wire logic [7:0] num,
   output logic            pin,
   output logic            busy
);
   // each level held whole clock cycles
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go === 1'b1) begin
            busy = 1'b1;
            repeat (num) begin
               #2 pin = 1'b1;
               repeat (hiCyc) @(posedge clk);
               #2 pin = 1'b0;
               repeat (loCyc) @(posedge clk);
            end
            busy = 1'b0;
         end
      end
   end
endmodule : stc_pulse_src

// [bench/test_sixteen_bit_timer_counter.sv]
`timescale 1ns/1ns
`define CHK(s, e, a) begin cmpCount++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %0h got %0h", s, e, a); end end
module test_sixteen_bit_timer_counter;
   typedef struct packed {logic [1:0] sel; logic [15:0] cmp, per;} stc_row_t;
   // rows: source clock, compare, interrupt period in cycles
   stc_row_t rows [3] = '{'{2'h2, 16'h0002, 16'h0006}, '{2'h1, 16'h0003, 16'h0020},
                         '{2'h3, 16'h0002, 16'h0180}};
   stc_pkg::stc_ctrl_t ctrl;
   logic clk, rst_b, startWrite, lowByteWr, highByteWr, stopModeEnter, matchIrq, go, pin, busy;
   logic [7:0] wrByte, hiCyc, loCyc, num;
   logic [1:0] startState;
   logic [15:0] countVal, captureVal, compareVal;
   int mismatches = 0, cmpCount = 0, irqCnt = 0, n, base;
   stc_timer stc_timer_inst (.clk, .rst_b, .ctrl, .startWrite, .lowByteWr, .highByteWr, .wrByte,
      .stopModeEnter, .slowMode(1'b0), .countInPin(pin), .startState, .countVal, .captureVal,
      .compareVal, .matchIrq);
   stc_pulse_src stc_pulse_src_inst (.clk, .go, .hiCyc, .loCyc, .num, .pin, .busy);
   initial begin clk = 1'b0; forever #20 clk = ~clk; end
   always @(negedge clk) if (matchIrq === 1'b1) irqCnt++;
   task cyc(input int k); repeat (k) @(posedge clk); #2; endtask : cyc
   task print_verdict;
      if (mismatches == 0 && cmpCount > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task start(input logic [1:0] s);
      ctrl.startCtl = s; startWrite = 1'b1; cyc(1); startWrite = 1'b0; cyc(1);
   endtask : start
   task setCmp(input logic [15:0] v);
      wrByte = v[7:0]; lowByteWr = 1'b1; cyc(1);
      lowByteWr = 1'b0; highByteWr = 1'b1; wrByte = v[15:8]; cyc(1);
      highByteWr = 1'b0; cyc(130);
      `CHK("compare", v, compareVal)
   endtask : setCmp
   task waitIrq;
      n = 0;
      do begin cyc(1); n++; end while (matchIrq !== 1'b1 && n < 1000);
      if (matchIrq !== 1'b1) begin mismatches++; print_verdict; end
   endtask : waitIrq
   task pulses(input logic [7:0] h, l, c);
      hiCyc = h; loCyc = l; num = c; go = 1'b1; cyc(1); go = 1'b0; n = 0;
      while (busy === 1'b1 && n < 3000) begin cyc(1); n++; end
      if (n >= 3000) begin mismatches++; print_verdict; end
   endtask : pulses
   initial begin
      ctrl = '0; rst_b = 1'b0; startWrite = 1'b0; lowByteWr = 1'b0; highByteWr = 1'b0;
      stopModeEnter = 1'b0; wrByte = 8'h00; go = 1'b0; hiCyc = 8'h00; loCyc = 8'h00; num = 8'h00;
      cyc(4);
      rst_b = 1'b1;
      `CHK("compare", 16'hffff, compareVal)
      `CHK("state", 2'h0, startState)
      wrByte = 8'h05; lowByteWr = 1'b1; cyc(1); lowByteWr = 1'b0; cyc(200);
      `CHK("low only", 16'hffff, compareVal)
      foreach (rows[i]) begin
         start(stc_pkg::STC_START_STOP);
         ctrl.srcClkSel = rows[i].sel;
         setCmp(rows[i].cmp);
         start(stc_pkg::STC_START_CMD);
         waitIrq;
         waitIrq;
         `CHK("period", rows[i].per, 16'(n))
      end
      start(stc_pkg::STC_START_STOP);
      ctrl.srcClkSel = 2'h2; ctrl.autoCapEn = 1'b1;
      setCmp(16'h0064);
      start(stc_pkg::STC_START_CMD);
      cyc(21);
      `CHK("capture", 1'b1, (countVal - captureVal) <= 16'h0001)
      stopModeEnter = 1'b1; cyc(1); stopModeEnter = 1'b0; cyc(1);
      `CHK("stop", 2'h0, startState)
      `CHK("stop count", 16'h0000, countVal)
      ctrl.autoCapEn = 1'b0; ctrl.modeSel = stc_pkg::STC_MODE_EVENT;
      setCmp(16'h0003);
      start(stc_pkg::STC_START_RISE);
      pulses(8'h04, 8'h08, 8'h02);
      `CHK("noise", 16'h0000, countVal)
      base = irqCnt;
      pulses(8'h0c, 8'h0c, 8'h03);
      `CHK("events", base + 1, irqCnt)
      start(stc_pkg::STC_START_STOP);
      ctrl.modeSel = stc_pkg::STC_MODE_EXT;
      ctrl.autoCapEn = 1'b1;
      setCmp(16'h0064);
      for (int t = 1; t >= 0; t--) begin
         start(stc_pkg::STC_START_STOP);
         ctrl.trigStopSel = t[0];
         start(stc_pkg::STC_START_RISE);
         base = irqCnt;
         pulses(8'h1e, 8'hf0, 8'h01);
         `CHK("trigger", base + 1 - t, irqCnt)
         `CHK("halted", 16'h0000, countVal)
      end
      start(stc_pkg::STC_START_STOP);
      ctrl.modeSel = stc_pkg::STC_MODE_WIN;
      setCmp(16'h0003);
      start(stc_pkg::STC_START_CMD);
      cyc(100);
      `CHK("gated", 16'h0000, countVal)
      base = irqCnt;
      pulses(8'h3c, 8'h0a, 8'h01);
      `CHK("window", 1'b1, irqCnt > base)
      start(stc_pkg::STC_START_STOP);
      base = irqCnt;
      start(stc_pkg::STC_START_FALL);
      cyc(20);
      `CHK("negative window", 1'b1, irqCnt > base)
      rst_b = 1'b0;
      cyc(1);
      `CHK("reset count", 16'h0000, countVal)
      `CHK("reset compare", 16'hffff, compareVal)
      `CHK("reset state", 2'h0, startState)
      rst_b = 1'b1;
      cyc(2);
      `CHK("reset hold", 16'h0000, countVal)
      `CHK("reset irq", 1'b0, matchIrq)
      print_verdict;
   end
endmodule : test_sixteen_bit_timer_counter
